// ---- hw/sfr_reset_recovery.sv ----
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module sfr_reset_recovery #(
  // Long recoveries, shortenable in simulation
  parameter logic [sfr_pkg::TMR_W-1:0] PROGRAM_REC_CYC =
    sfr_pkg::TMR_W'(sfr_pkg::REC_PROGRAM_CYCLES),
  parameter logic [sfr_pkg::TMR_W-1:0] SECTOR_REC_CYC =
    sfr_pkg::TMR_W'(sfr_pkg::REC_SECTOR_ERASE_CYCLES),
  parameter logic [sfr_pkg::TMR_W-1:0] BLOCK_REC_CYC =
    sfr_pkg::TMR_W'(sfr_pkg::REC_BLOCK_ERASE_CYCLES),
  parameter logic [sfr_pkg::TMR_W-1:0] CHIP_REC_CYC =
    sfr_pkg::TMR_W'(sfr_pkg::REC_CHIP_ERASE_CYCLES),
  parameter logic [sfr_pkg::TMR_W-1:0] SWRITE_REC_CYC =
    sfr_pkg::TMR_W'(sfr_pkg::REC_STATUS_WRITE_CYCLES)
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic hw_reset_n_in,
  input wire logic chip_select_n_in,
  input wire logic serial_out_drive_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic [sfr_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [sfr_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [sfr_pkg::DATA_W-1:0] reg_rdata_out,
  output logic serial_out_oe_out,
  output logic low_power_out,
  output logic op_abort_out,
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic ready_out,
  output logic write_enable_latch_out,
  output logic write_in_progress_out,
  output logic lock_bit_out,
  output logic addr_4byte_out
);

  // Whole state of the sequencer
  typedef struct packed {
    sfr_pkg::sfr_state_t st; // Sequencer phase
    logic [1:0] rst_sync; // Reset pin synchroniser
    logic [1:0] cs_sync; // Select pin synchroniser
    logic [sfr_pkg::LOW_CNT_W-1:0] low_cnt; // Cycles seen low
    logic low_done; // Pulse long enough to count
    sfr_pkg::sfr_op_t op; // Operation running now
    sfr_pkg::sfr_op_t rec_op; // Operation the reset hit
    logic fresh; // No command since power-on
    logic write_enable_latch; // Write enable latch
    logic write_in_progress; // Write in progress
    logic lock; // Volatile lock bit
    logic addr4; // Four-byte addressing
    logic oe; // Serial out enable
    logic low_pwr; // Activity cut to minimum
    logic abort; // Abort pulse to the array
    logic ready; // Commands accepted
    logic [7:0] cmd; // Passed command byte
    logic cmd_vld; // Passed command strobe
    logic tmr_load; // Timer load pulse
    logic [sfr_pkg::TMR_W-1:0] tmr_count; // Timer load value
    logic [sfr_pkg::DATA_W-1:0] rdata; // Read answer
  } sfr_main_t;

  // Power-up state: standby, latch cleared, never deep power-down
  localparam sfr_main_t MAIN_RST = '{
    st: sfr_pkg::ST_STANDBY,
    rst_sync: sfr_pkg::SYNC_IDLE,
    cs_sync: sfr_pkg::SYNC_IDLE,
    low_cnt: '0,
    low_done: 1'b0,
    op: sfr_pkg::OP_NONE,
    rec_op: sfr_pkg::OP_NONE,
    fresh: 1'b1,
    write_enable_latch: 1'b0,
    write_in_progress: 1'b0,
    lock: 1'b0,
    addr4: 1'b0,
    oe: 1'b0,
    low_pwr: 1'b0,
    abort: 1'b0,
    ready: 1'b1,
    cmd: '0,
    cmd_vld: 1'b0,
    tmr_load: 1'b0,
    tmr_count: '0,
    rdata: '0
  };

  localparam logic [sfr_pkg::LOW_CNT_W-1:0] LOW_MAX =
    sfr_pkg::LOW_CNT_W'(sfr_pkg::RESET_LOW_CYCLES);

  sfr_main_t q;
  sfr_main_t d;
  logic rst_low; // Synchronised reset pin is low
  logic cs_low; // Synchronised select pin is low
  sfr_pkg::sfr_op_t live_op; // What a reset would interrupt now
  sfr_pkg::sfr_op_t new_op; // Operation written by software

  sfr_tmr_if tmr_bus ();

  // Operations whose interruption leaves the array or latch altered
  function automatic logic is_write_op(input sfr_pkg::sfr_op_t op);
    is_write_op = (op == sfr_pkg::OP_PROGRAM) || (op == sfr_pkg::OP_SECTOR_ERASE) ||
                  (op == sfr_pkg::OP_BLOCK_ERASE) || (op == sfr_pkg::OP_CHIP_ERASE) ||
                  (op == sfr_pkg::OP_STATUS_WRITE);
  endfunction

  // Recovery wait chosen by what the reset interrupted
  function automatic logic [sfr_pkg::TMR_W-1:0] rec_cycles(input sfr_pkg::sfr_op_t op,
                                                           input logic fresh);
    if (fresh && (op == sfr_pkg::OP_NONE)) begin
      rec_cycles = sfr_pkg::TMR_W'(sfr_pkg::REC_POWER_ON_CYCLES);
    end else begin
      case (op)
        sfr_pkg::OP_READ: rec_cycles = sfr_pkg::TMR_W'(sfr_pkg::REC_READ_CYCLES);
        sfr_pkg::OP_PROGRAM: rec_cycles = PROGRAM_REC_CYC;
        sfr_pkg::OP_SECTOR_ERASE: rec_cycles = SECTOR_REC_CYC;
        sfr_pkg::OP_BLOCK_ERASE: rec_cycles = BLOCK_REC_CYC;
        sfr_pkg::OP_CHIP_ERASE: rec_cycles = CHIP_REC_CYC;
        sfr_pkg::OP_STATUS_WRITE: rec_cycles = SWRITE_REC_CYC;
        // Idle or decoding: the decode figure, safe for an idle part too
        default: rec_cycles = sfr_pkg::TMR_W'(sfr_pkg::REC_DECODE_CYCLES);
      endcase
    end
  endfunction

  // Only the second synchroniser stage is looked at
  assign rst_low = !q.rst_sync[1];
  assign cs_low = !q.cs_sync[1];
  assign new_op = sfr_pkg::sfr_op_t'(reg_wdata_in[sfr_pkg::OP_LSB +: sfr_pkg::OP_W]);

  // A select without an array operation means an instruction is decoding
  always_comb begin
    if ((q.op == sfr_pkg::OP_NONE) && cs_low) begin
      live_op = sfr_pkg::OP_DECODE;
    end else begin
      live_op = q.op;
    end
  end

  // Next state of the whole sequencer
  always_comb begin
    d = q;
    d.rst_sync = {q.rst_sync[0], hw_reset_n_in};
    d.cs_sync = {q.cs_sync[0], chip_select_n_in};
    d.abort = 1'b0;
    d.cmd_vld = 1'b0;
    d.tmr_load = 1'b0;
    d.rdata = '0;

    case (q.st)
      // Normal service; a falling reset pin starts width measurement
      sfr_pkg::ST_STANDBY: begin
        if (rst_low) begin
          d.st = sfr_pkg::ST_RESET_LOW;
          d.low_cnt = sfr_pkg::LOW_CNT_W'(1);
          d.low_done = 1'b0;
          d.rec_op = live_op;
        end
      end
      // Pin held low: count it, act once it is wide enough
      sfr_pkg::ST_RESET_LOW: begin
        if (rst_low) begin
          if (!q.low_done && (q.low_cnt >= LOW_MAX - sfr_pkg::LOW_CNT_W'(1))) begin
            d.low_done = 1'b1;
            d.abort = is_write_op(q.op);
            d.op = sfr_pkg::OP_NONE;
            d.write_enable_latch = 1'b0;
            d.write_in_progress = 1'b0;
            d.lock = 1'b0;
            d.addr4 = 1'b0;
          end else if (!q.low_done) begin
            d.low_cnt = q.low_cnt + sfr_pkg::LOW_CNT_W'(1);
          end
        end else if (q.low_done) begin
          // Released after a full pulse: start the recovery wait
          d.st = sfr_pkg::ST_RECOVER;
          d.tmr_load = 1'b1;
          d.tmr_count = rec_cycles(q.rec_op, q.fresh);
        end else begin
          // Too short to be a reset; nothing was disturbed, but a glitch
          // inside recovery must not cut the wait short while the timer runs
          d.st = tmr_bus.done ? sfr_pkg::ST_STANDBY : sfr_pkg::ST_RECOVER;
        end
      end
      // Waiting out recovery; a new pulse restarts the measurement
      sfr_pkg::ST_RECOVER: begin
        if (rst_low) begin
          d.st = sfr_pkg::ST_RESET_LOW;
          d.low_cnt = sfr_pkg::LOW_CNT_W'(1);
          d.low_done = 1'b0;
        end else if (tmr_bus.done && !q.tmr_load) begin
          d.st = sfr_pkg::ST_STANDBY;
        end
      end
      default: begin
        d.st = sfr_pkg::ST_STANDBY;
      end
    endcase

    // Command bytes pass only while ready; the rest are dropped
    if ((q.st == sfr_pkg::ST_STANDBY) && !rst_low && cmd_valid_in && cs_low) begin
      d.cmd_vld = 1'b1;
      d.cmd = cmd_byte_in;
      d.fresh = 1'b0;
    end

    // Register writes are honoured only in standby
    if (reg_wr_in && (q.st == sfr_pkg::ST_STANDBY) && !rst_low) begin
      case (reg_addr_in)
        sfr_pkg::REG_CTRL: begin
          d.write_enable_latch = reg_wdata_in[sfr_pkg::CTRL_WEL_BIT];
          d.lock = reg_wdata_in[sfr_pkg::CTRL_LOCK_BIT];
          d.addr4 = reg_wdata_in[sfr_pkg::CTRL_ADDR4_BIT];
        end
        sfr_pkg::REG_OP: begin
          if (new_op == sfr_pkg::OP_NONE) begin
            // Completion: a finished write disarms the latch
            if (is_write_op(q.op)) begin
              d.write_enable_latch = 1'b0;
            end
            d.write_in_progress = 1'b0;
            d.op = sfr_pkg::OP_NONE;
          end else if ((q.op == sfr_pkg::OP_NONE) && (new_op != sfr_pkg::OP_DECODE)) begin
            // Writes need the latch armed, as the array would demand
            if (!is_write_op(new_op) || q.write_enable_latch) begin
              d.op = new_op;
              d.write_in_progress = is_write_op(new_op);
              d.fresh = 1'b0;
            end
          end
        end
        default: begin
          // Unmapped or read-only offset: write has no effect
        end
      endcase
    end

    // Read answer stands for exactly the following cycle
    if (reg_rd_in) begin
      case (reg_addr_in)
        sfr_pkg::REG_CTRL: begin
          d.rdata[sfr_pkg::CTRL_WEL_BIT] = q.write_enable_latch;
          d.rdata[sfr_pkg::CTRL_LOCK_BIT] = q.lock;
          d.rdata[sfr_pkg::CTRL_ADDR4_BIT] = q.addr4;
        end
        sfr_pkg::REG_OP: begin
          d.rdata[sfr_pkg::OP_LSB +: sfr_pkg::OP_W] = q.op;
        end
        sfr_pkg::REG_STATUS: begin
          d.rdata[sfr_pkg::STAT_READY_BIT] = q.ready;
          d.rdata[sfr_pkg::STAT_WIP_BIT] = q.write_in_progress;
          d.rdata[sfr_pkg::STAT_WEL_BIT] = q.write_enable_latch;
          d.rdata[sfr_pkg::STAT_LOCK_BIT] = q.lock;
          d.rdata[sfr_pkg::STAT_ADDR4_BIT] = q.addr4;
          d.rdata[sfr_pkg::STAT_FRESH_BIT] = q.fresh;
          d.rdata[sfr_pkg::STAT_RSTLOW_BIT] = q.low_pwr;
          d.rdata[sfr_pkg::STAT_RECOP_LSB +: sfr_pkg::OP_W] = q.rec_op;
          d.rdata[sfr_pkg::STAT_OP_LSB +: sfr_pkg::OP_W] = q.op;
        end
        default: begin
          // Unmapped offsets read as zero
        end
      endcase
    end

    // Output qualifiers follow the next phase so they change with it
    d.ready = (d.st == sfr_pkg::ST_STANDBY) && !rst_low;
    d.oe = serial_out_drive_in && (d.st == sfr_pkg::ST_STANDBY) && !rst_low;
    d.low_pwr = (d.st == sfr_pkg::ST_RESET_LOW);
  end

  // State register; power-up lands in standby with the latch clear
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      q <= MAIN_RST;
    end else begin
      q <= d;
    end
  end

  // Timer hookup
  assign tmr_bus.load = q.tmr_load;
  assign tmr_bus.count = q.tmr_count;

  sfr_recovery_timer u_timer (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .tmr(tmr_bus)
  );

  // Every output comes straight from the state register
  assign reg_rdata_out = q.rdata;
  assign serial_out_oe_out = q.oe;
  assign low_power_out = q.low_pwr;
  assign op_abort_out = q.abort;
  assign cmd_valid_out = q.cmd_vld;
  assign cmd_byte_out = q.cmd;
  assign ready_out = q.ready;
  assign write_enable_latch_out = q.write_enable_latch;
  assign write_in_progress_out = q.write_in_progress;
  assign lock_bit_out = q.lock;
  assign addr_4byte_out = q.addr4;

endmodule

// ---- hw/sfr_pkg.sv ----
// Shared constants and types for the serial flash reset and recovery logic
package sfr_pkg;

  // System clock period
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned NS_PER_MS = 1000000;

  // Least reset pulse width and the power-on, decode, read and program recoveries, in microseconds
  localparam int unsigned RESET_LOW_WIDTH_US = 10;
  localparam int unsigned REC_POWER_ON_US = 35;
  localparam int unsigned REC_DECODE_US = 40;
  localparam int unsigned REC_READ_US = 40;
  localparam int unsigned REC_PROGRAM_US = 310;
  // Recovery after an interrupted erase or status write, in milliseconds
  localparam int unsigned REC_SECTOR_ERASE_MS = 12;
  localparam int unsigned REC_BLOCK_ERASE_MS = 25;
  localparam int unsigned REC_CHIP_ERASE_MS = 1000;
  localparam int unsigned REC_STATUS_WRITE_MS = 40;

  // Least times round up to whole cycles
  localparam int unsigned RESET_LOW_CYCLES =
    (RESET_LOW_WIDTH_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_POWER_ON_CYCLES =
    (REC_POWER_ON_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_DECODE_CYCLES =
    (REC_DECODE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_READ_CYCLES =
    (REC_READ_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_PROGRAM_CYCLES =
    (REC_PROGRAM_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_SECTOR_ERASE_CYCLES = REC_SECTOR_ERASE_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned REC_BLOCK_ERASE_CYCLES = REC_BLOCK_ERASE_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned REC_CHIP_ERASE_CYCLES = REC_CHIP_ERASE_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned REC_STATUS_WRITE_CYCLES = REC_STATUS_WRITE_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // Widths
  localparam int unsigned TMR_W = 27;
  localparam int unsigned LOW_CNT_W = 11;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_OP = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_WEL_BIT = 0;
  localparam int unsigned CTRL_LOCK_BIT = 1;
  localparam int unsigned CTRL_ADDR4_BIT = 2;
  // Operation register field
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned OP_W = 3;
  // Status register fields
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_WIP_BIT = 1;
  localparam int unsigned STAT_WEL_BIT = 2;
  localparam int unsigned STAT_LOCK_BIT = 3;
  localparam int unsigned STAT_ADDR4_BIT = 4;
  localparam int unsigned STAT_FRESH_BIT = 5;
  localparam int unsigned STAT_RSTLOW_BIT = 6;
  localparam int unsigned STAT_RECOP_LSB = 8;
  localparam int unsigned STAT_OP_LSB = 12;

  // Idle level of a synchroniser on a high-idle pin
  localparam logic [1:0] SYNC_IDLE = 2'h3;

  // Operation that is running in the array
  typedef enum logic [2:0] {
    OP_NONE, OP_DECODE, OP_READ, OP_PROGRAM,
    OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_STATUS_WRITE
  } sfr_op_t;

  // Reset sequencer phases
  typedef enum logic [1:0] {
    ST_STANDBY, ST_RESET_LOW, ST_RECOVER
  } sfr_state_t;

endpackage

// ---- hw/sfr_tmr_if.sv ----
`timescale 1ns/1ps
// Load and done handshake between the sequencer and its recovery timer
interface sfr_tmr_if;
  logic load; // One-cycle load pulse
  logic [sfr_pkg::TMR_W-1:0] count; // Cycles to wait, valid with load
  logic done; // Level, high once the wait has elapsed
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// ---- hw/sfr_recovery_timer.sv ----
`timescale 1ns/1ps
// Down counter that holds done high once a loaded wait has run out
module sfr_recovery_timer (
  input wire logic mclk_in,
  input wire logic srst_in,
  sfr_tmr_if.tmr tmr
);

  // Whole state of the timer
  typedef struct packed {
    logic [sfr_pkg::TMR_W-1:0] cnt; // Cycles still to run
    logic done; // Wait finished
  } sfr_tmr_state_t;

  sfr_tmr_state_t q;
  sfr_tmr_state_t d;

  // Next state: a load always restarts, even mid-count
  always_comb begin
    d = q;
    if (tmr.load) begin
      d.cnt = tmr.count;
      d.done = 1'b0;
    end else if (!q.done) begin
      // Done lands no sooner than count cycles after the load
      if (q.cnt <= sfr_pkg::TMR_W'(1)) begin
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - sfr_pkg::TMR_W'(1);
      end
    end
  end

  // State register; idle timer reads as done
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      q <= '{cnt: '0, done: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign tmr.done = q.done;

endmodule

// ---- test/sfr_chk.sv ----
`timescale 1ns/1ps
// Port-level watcher for the reset and recovery sequencer
module sfr_chk #(
  parameter int unsigned MIN_REC_CYC = 100
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic hw_reset_n_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic serial_out_oe_out,
  input wire logic low_power_out,
  input wire logic op_abort_out,
  input wire logic cmd_valid_out,
  input wire logic [7:0] cmd_byte_out,
  input wire logic ready_out,
  input wire logic write_enable_latch_out,
  input wire logic write_in_progress_out,
  input wire logic lock_bit_out,
  input wire logic addr_4byte_out
);
  // Slack for the two synchroniser stages and the output register
  localparam int ABORT_MIN = 992;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  logic [31:0] low_len_q; // Cycles spent in reset low
  logic [31:0] rec_cnt_q; // Cycles since reset low ended, saturating
  logic long_q; // Last low spell was long enough for a full reset
  // Measures each low spell and the recovery behind it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      low_len_q <= '0;
      rec_cnt_q <= '0;
      long_q <= 1'b0;
    end else if (low_power_out) begin
      low_len_q <= low_len_q + 32'h1;
      rec_cnt_q <= '0;
      // Old count trails the spell by one, so a spell of exactly the minimum counts
      long_q <= (low_len_q >= sfr_pkg::RESET_LOW_CYCLES - 1);
    end else begin
      low_len_q <= '0;
      // Saturate so a long idle never wraps into a false short count
      if (rec_cnt_q != '1) begin
        rec_cnt_q <= rec_cnt_q + 32'h1;
      end
    end
  end
  sequence s_pin_low;
    !hw_reset_n_in [*5];
  endsequence
  sequence s_long_release;
    long_q && $rose(ready_out);
  endsequence
  lowpwr_entry_a: assert property (s_pin_low |-> low_power_out)
    else $error("low power missing while reset held");
  oe_reset_a: assert property (low_power_out |-> !serial_out_oe_out)
    else $error("serial out driven during reset");
  ready_low_a: assert property (low_power_out |-> !ready_out)
    else $error("ready high during reset");
  oe_recover_a: assert property (!ready_out && !$past(ready_out) |-> !serial_out_oe_out)
    else $error("serial out driven while not ready");
  cmd_drop_a: assert property (cmd_valid_in && !ready_out |=> !cmd_valid_out)
    else $error("command accepted while not ready");
  cmd_pass_a: assert property (cmd_valid_out |-> $past(cmd_valid_in)
    && $past(ready_out) && cmd_byte_out == $past(cmd_byte_in))
    else $error("command out without a matching accepted byte");
  abort_clear_a: assert property (op_abort_out |=> !write_enable_latch_out
    && !write_in_progress_out && !lock_bit_out && !addr_4byte_out)
    else $error("volatile state kept after abort");
  abort_inreset_a: assert property (op_abort_out |-> low_power_out
    && low_len_q >= ABORT_MIN)
    else $error("abort without a full reset pulse");
  recovery_min_a: assert property (s_long_release |-> rec_cnt_q >= MIN_REC_CYC - 4)
    else $error("ready returned before recovery elapsed");
endmodule

// ---- test/sfr_host_model.sv ----
`timescale 1ns/1ps
// Host side: drives the reset pin and the select pin
module sfr_host_model #(
  parameter int unsigned GAP_CYC = 1000,
  parameter int unsigned PUP_CYC = 16
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic pulse_in,
  input wire logic [15:0] width_in,
  input wire logic sel_in,
  output logic hw_reset_n_out,
  output logic chip_select_n_out,
  output logic busy_out
);
  logic [15:0] low_q; // Cycles of reset low still to go
  logic [15:0] gap_q; // Cycles before select may fall
  // Pin is held low for the whole commanded width, then a guard gap runs
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      low_q <= '0;
      gap_q <= 16'(PUP_CYC);
    end else if (pulse_in && low_q == '0) begin
      low_q <= width_in;
    end else if (low_q != '0) begin
      low_q <= low_q - 16'h1;
      gap_q <= 16'(GAP_CYC);
    end else if (gap_q != '0) begin
      gap_q <= gap_q - 16'h1;
    end
  end
  assign hw_reset_n_out = (low_q == '0);
  assign busy_out = (low_q != '0) || (gap_q != '0);
  // Select stays high until the guard gap is over
  assign chip_select_n_out = !(sel_in && !busy_out);
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench for the reset and recovery sequencer
module testbench;
  // Shortened long recoveries, kept distinct
  localparam logic [26:0] PRC = 27'h78;
  localparam logic [26:0] SRC = 27'h8c;
  localparam logic [26:0] BRC = 27'ha0;
  localparam logic [26:0] CRC = 27'hb4;
  localparam logic [26:0] WRC = 27'hc8;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic drive = 1'b1, cmd_v = 1'b0, wr = 1'b0, rd = 1'b0, pulse = 1'b0, sel = 1'b0;
  logic [7:0] cmd_b = 8'h00;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] width = 16'h0;
  logic [31:0] rdata;
  logic [7:0] cbo;
  logic rst_n, cs_n, oe, lp, abrt, cvo, rdy, write_enable_latch, write_in_progress, lck, a4;
  integer seed = 32'h85f4;
  int num_errors = 0, n_compared = 0, n_abort = 0;
  // Free-running system clock
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  sfr_host_model host_u (.mclk_in(mclk_in), .srst_in(srst_in), .pulse_in(pulse),
    .width_in(width), .sel_in(sel), .hw_reset_n_out(rst_n), .chip_select_n_out(cs_n),
    .busy_out());
  sfr_reset_recovery #(.PROGRAM_REC_CYC(PRC), .SECTOR_REC_CYC(SRC), .BLOCK_REC_CYC(BRC),
    .CHIP_REC_CYC(CRC), .SWRITE_REC_CYC(WRC)) dut_u (.mclk_in(mclk_in), .srst_in(srst_in),
    .hw_reset_n_in(rst_n), .chip_select_n_in(cs_n), .serial_out_drive_in(drive),
    .cmd_valid_in(cmd_v), .cmd_byte_in(cmd_b), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .serial_out_oe_out(oe),
    .low_power_out(lp), .op_abort_out(abrt), .cmd_valid_out(cvo), .cmd_byte_out(cbo),
    .ready_out(rdy), .write_enable_latch_out(write_enable_latch), .write_in_progress_out(write_in_progress),
    .lock_bit_out(lck), .addr_4byte_out(a4));
  // Counts abort pulses, seen as the previous cycle's value
  always @(posedge mclk_in) begin
    if (abrt === 1'b1) begin
      n_abort++;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Expected recovery for the operation cut short
  function automatic int unsigned rec_of(input logic [2:0] op);
    case (op)
      3'h2: return sfr_pkg::REC_READ_CYCLES;
      3'h3: return PRC;
      3'h4: return SRC;
      3'h5: return BRC;
      3'h6: return CRC;
      3'h7: return WRC;
      default: return sfr_pkg::REC_DECODE_CYCLES;
    endcase
  endfunction
  // Ready may trail the minimum by the synchroniser and register delay
  function automatic logic [31:0] in_win(input int r, input int unsigned n);
    return 32'(r >= n && r <= n + 8);
  endfunction
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic send_cmd(input logic [7:0] b);
    @(posedge mclk_in);
    cmd_v <= 1'b1;
    cmd_b <= b;
    @(posedge mclk_in);
    cmd_v <= 1'b0;
    #1;
    check(32'(cvo), 32'h1);
    check(32'(cbo), 32'(b));
  endtask
  // Counts cycles to ready; pokes a random byte at cycle 1500 of the wait, if still not ready, which must be dropped
  task automatic wait_ready(output int n);
    n = 0;
    while (rdy !== 1'b1) begin
      @(posedge mclk_in);
      cmd_v <= (n == 1500);
      cmd_b <= 8'($random(seed));
      #1;
      if (n == 1501) begin
        check(32'(cvo), 32'h0);
      end
      n++;
      if (n > 20000) begin
        num_errors++;
        report_and_stop;
      end
    end
  endtask
  task automatic hw_pulse(input logic [15:0] w, output int rec);
    @(posedge mclk_in);
    pulse <= 1'b1;
    width <= w;
    @(posedge mclk_in);
    pulse <= 1'b0;
    repeat (w - 16'h5) @(posedge mclk_in);
    #1;
    check(32'({lp, oe, rdy}), 32'h4);
    repeat (5) @(posedge mclk_in);
    #1;
    wait_ready(rec);
    check(32'({lp, oe, rdy}), 32'h3);
  endtask
  initial begin
    int rec;
    logic [31:0] st;
    logic [2:0] op;
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    check(32'({rdy, write_enable_latch, lp}), 32'h4);
    sel <= 1'b1;
    hw_pulse(16'h3e8 + 16'($random(seed) & 32'h1f), rec);
    check(in_win(rec, sfr_pkg::REC_POWER_ON_CYCLES), 32'h1);
    $display("power-on recovery test done");
    send_cmd(8'($random(seed)));
    hw_pulse(16'h3e8, rec);
    check(in_win(rec, sfr_pkg::REC_DECODE_CYCLES), 32'h1);
    send_cmd(8'h9f);
    $display("idle recovery test done");
    reg_wr(sfr_pkg::REG_CTRL, 32'h1);
    hw_pulse(16'h1f4, rec);
    check(32'(write_enable_latch), 32'h1);
    reg_rd(4'hc, st);
    check(st, 32'h0);
    $display("short pulse test done");
    for (int i = 2; i < 8; i++) begin
      op = 3'(i);
      reg_wr(sfr_pkg::REG_CTRL, 32'h7);
      reg_wr(sfr_pkg::REG_OP, 32'(op));
      reg_rd(sfr_pkg::REG_STATUS, st);
      check(32'(st[sfr_pkg::STAT_OP_LSB +: 3]), 32'(op));
      check(32'(st[sfr_pkg::STAT_WEL_BIT +: 3]), 32'h7);
      check(32'(st[sfr_pkg::STAT_WIP_BIT]), 32'(op > 3'h2));
      n_abort = 0;
      hw_pulse(16'h3e8 + 16'($random(seed) & 32'h1f), rec);
      check(in_win(rec, rec_of(op)), 32'h1);
      check(32'(n_abort), 32'(op > 3'h2));
      check(32'({write_enable_latch, write_in_progress, lck, a4}), 32'h0);
      $display("abort test %0d done", i);
    end
    reg_wr(sfr_pkg::REG_CTRL, 32'h1);
    srst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    #1;
    check(32'({rdy, write_enable_latch, lp}), 32'h4);
    $display("second power-on test done");
    report_and_stop;
  end
endmodule
bind sfr_reset_recovery sfr_chk #(.MIN_REC_CYC(120)) chk_u (.mclk_in(mclk_in),
  .srst_in(srst_in), .hw_reset_n_in(hw_reset_n_in), .cmd_valid_in(cmd_valid_in),
  .cmd_byte_in(cmd_byte_in), .serial_out_oe_out(serial_out_oe_out),
  .low_power_out(low_power_out), .op_abort_out(op_abort_out),
  .cmd_valid_out(cmd_valid_out), .cmd_byte_out(cmd_byte_out), .ready_out(ready_out),
  .write_enable_latch_out(write_enable_latch_out),
  .write_in_progress_out(write_in_progress_out), .lock_bit_out(lock_bit_out),
  .addr_4byte_out(addr_4byte_out));
